// [rtl/reference_modifier_pid_select.sv]
// Purpose: Modifies the drive reference and selects the active parameter set
// Assumes: APB slave, values in hundredths of percent or hertz
// Notes:   One wait state on every APB access
// Functional notes
// - Source select; none leaves reference unchanged
// - Normal sense raises the reference
// - Inverse sense lowers the reference
// - Lower extent applies at source minimum
// - Upper extent applies at source maximum
// - Discrete step per active input or unit
// - Gradient scales against full or reference
// - Control mode clamps to frequency limits
// - One percent equals one hertz
// - Regulation clamps to reference limits
// - Extender modifies in control mode only
// - Variable normal: ref minus lower plus scaled
// - Variable inverse: ref plus lower minus scaled
// - Discrete normal adds count times step
// - Discrete inverse subtracts count times step
// - Regulation uses selected parameter set
// - Frequency choice switches at change-over points
// - Each set holds four ranged values
// - Integral time off disables integral term
// - Sets two to four match set one
// - Error equals reference minus feedback
`timescale 1ns/100ps
`include "rm_map.svh"
module reference_modifier_pid_select
  import rm_pkg::*;
#(
  parameter int VW = 18
)(
  input  wire logic              clock_i,
  input  wire logic              rst_i,
  input  wire logic              psel_i,
  input  wire logic              penable_i,
  input  wire logic              pwrite_i,
  input  wire logic [7:0]        paddr_i,
  input  wire logic [31:0]       pwdata_i,
  output logic      [31:0]       prdata_o,
  output logic                   pready_o,
  output logic                   pslverr_o,
  input  wire logic [VW-1:0]     ref_i,
  input  wire logic [VW-1:0]     feedback_i,
  input  wire logic [15:0]       out_freq_i,
  input  wire logic [7:0]        dig_in_i,
  input  wire logic [5:0]        virt_in_i,
  input  wire logic [3:0]        ext_units_i,
  input  wire logic [3:0][15:0]  analog_i,
  input  wire logic [15:0]       motor_pot_i,
  output logic      [VW-1:0]     mod_ref_o,
  output logic signed [VW:0]     error_o,
  output pid_set_t               active_set_o,
  output set_idx_t               set_idx_o,
  output logic                   integral_on_o
);

  ctrl_t        ctrl_reg;
  logic [15:0]  lower_reg;
  logic [15:0]  upper_reg;
  logic [15:0]  disc_reg;
  logic [VW-1:0] fmin_reg;
  logic [VW-1:0] fmax_reg;
  logic [VW-1:0] rmin_reg;
  logic [VW-1:0] rmax_reg;
  changeover_t  co_reg;
  pid_set_t     pid_reg [4];
  logic [7:0]   dig_level;
  set_idx_t     set_sel;
  logic         wr_en;
  logic         addr_hit;
  logic         pid_hit;
  logic [31:0]  rdata;
  logic [3:0]   n_units;
  logic [15:0]  var_val;
  logic signed [39:0] delta_raw;
  logic signed [39:0] delta_scaled;
  logic signed [39:0] delta_signed;
  logic signed [39:0] sum;
  logic [VW-1:0] lo_lim;
  logic [VW-1:0] hi_lim;
  logic [VW-1:0] mod_ref_next;

  default clocking @(posedge clock_i); endclocking
  default disable iff (rst_i);

  // Saturate a written value into its legal range
  function automatic logic [31:0] lim(input logic [31:0] v, input logic [31:0] lo,
                                      input logic [31:0] hi);
    if (v < lo)
    begin
      return lo;
    end
    return (v > hi) ? hi : v;
  endfunction

  // Number of active digital and virtual inputs
  function automatic logic [3:0] count_on(input logic [13:0] v);
    logic [3:0] c;
    c = 4'h0;
    for (int i = 0; i < 14; i++)
    begin
      c = c + {3'h0, v[i]};
    end
    return c;
  endfunction

  // Digital inputs arrive from pins
  rm_pin_sync #(
    .W (8)
  ) u_dig_sync (
    .clock_i (clock_i),
    .rst_i   (rst_i),
    .pin_i   (dig_in_i),
    .level_o (dig_level)
  );

  // Parameter set choice
  rm_pid_select u_select (
    .clock_i (clock_i),
    .rst_i   (rst_i),
    .sel_i   (ctrl_reg.pid_sel),
    .freq_i  (out_freq_i),
    .co_i    (co_reg),
    .set_o   (set_sel)
  );

  // APB decode
  assign wr_en   = psel_i && penable_i && pready_o && pwrite_i && addr_hit;
  assign pid_hit = paddr_i[7:6] == `RM_PID_REGION && paddr_i[1:0] == 2'h0;
  assign addr_hit = pid_hit || (paddr_i[1:0] == 2'h0 && paddr_i <= `RM_OFF_STATUS);

  // One wait state, error on unmapped address
  always_ff @(posedge clock_i)
  begin
    if (rst_i)
    begin
      pready_o  <= 1'b0;
      pslverr_o <= 1'b0;
      prdata_o  <= 32'h0000_0000;
    end
    else if (psel_i && penable_i && !pready_o)
    begin
      pready_o  <= 1'b1;
      pslverr_o <= !addr_hit;
      prdata_o  <= pwrite_i ? 32'h0000_0000 : rdata;
    end
    else
    begin
      pready_o  <= 1'b0;
      pslverr_o <= 1'b0;
    end
  end

  // Read mux
  always_comb
  begin
    rdata = 32'h0000_0000;
    if (pid_hit)
    begin
      case (paddr_i[3:2])
        2'h0:    rdata = {16'h0000, pid_reg[paddr_i[5:4]].proportional_gain};
        2'h1:    rdata = {14'h0000, pid_reg[paddr_i[5:4]].integral_time};
        2'h2:    rdata = {17'h00000, pid_reg[paddr_i[5:4]].derivative_time};
        default: rdata = {22'h000000, pid_reg[paddr_i[5:4]].boost};
      endcase
    end
    else
    begin
      case (paddr_i)
        `RM_OFF_CTRL:   rdata = {23'h000000, ctrl_reg};
        `RM_OFF_LOWER:  rdata = {16'h0000, lower_reg};
        `RM_OFF_UPPER:  rdata = {16'h0000, upper_reg};
        `RM_OFF_DISC:   rdata = {16'h0000, disc_reg};
        `RM_OFF_FMIN:   rdata = 32'(fmin_reg);
        `RM_OFF_FMAX:   rdata = 32'(fmax_reg);
        `RM_OFF_RMIN:   rdata = 32'(rmin_reg);
        `RM_OFF_RMAX:   rdata = 32'(rmax_reg);
        `RM_OFF_SW2:    rdata = {16'h0000, co_reg.sw2};
        `RM_OFF_SW3:    rdata = {16'h0000, co_reg.sw3};
        `RM_OFF_SW4:    rdata = {16'h0000, co_reg.sw4};
        `RM_OFF_HYST:   rdata = {24'h000000, co_reg.hyst};
        `RM_OFF_STATUS:
        begin
          rdata = 32'(mod_ref_o);
          rdata[`RM_ST_SET_LSB +: 2] = set_idx_o;
          rdata[`RM_ST_INT_BIT]      = integral_on_o;
        end
        default:        rdata = 32'h0000_0000;
      endcase
    end
  end

  // Modification settings, percent and change-over writes saturate into range, limit registers take the low VW bits
  always_ff @(posedge clock_i)
  begin
    if (rst_i)
    begin
      ctrl_reg  <= '{pid_sel: sel_one, regulation: 1'b0, grad_ref: 1'b0, inverse: 1'b0,
                     source: src_none};
      lower_reg <= `RM_LOWER_DEF;
      upper_reg <= `RM_UPPER_DEF;
      disc_reg  <= `RM_DISC_DEF;
      fmin_reg  <= `RM_FMIN_DEF;
      fmax_reg  <= `RM_FMAX_DEF;
      rmin_reg  <= `RM_RMIN_DEF;
      rmax_reg  <= `RM_RMAX_DEF;
      co_reg    <= '{sw2: `RM_SW2_DEF, sw3: `RM_SW3_DEF, sw4: `RM_SW4_DEF,
                     hyst: `RM_HYST_DEF};
    end
    else if (wr_en && !pid_hit)
    begin
      case (paddr_i)
        `RM_OFF_CTRL:  ctrl_reg  <= ctrl_t'(pwdata_i[8:0]);
        `RM_OFF_LOWER: lower_reg <= 16'(lim(pwdata_i, 32'h0, `RM_PCT_MAX));
        `RM_OFF_UPPER: upper_reg <= 16'(lim(pwdata_i, 32'h0, `RM_PCT_MAX));
        `RM_OFF_DISC:  disc_reg  <= 16'(lim(pwdata_i, 32'h0, `RM_PCT_MAX));
        `RM_OFF_FMIN:  fmin_reg  <= pwdata_i[VW-1:0];
        `RM_OFF_FMAX:  fmax_reg  <= pwdata_i[VW-1:0];
        `RM_OFF_RMIN:  rmin_reg  <= pwdata_i[VW-1:0];
        `RM_OFF_RMAX:  rmax_reg  <= pwdata_i[VW-1:0];
        `RM_OFF_SW2:   co_reg.sw2 <= 16'(lim(pwdata_i, `RM_SW_MIN, `RM_SW_MAX));
        `RM_OFF_SW3:   co_reg.sw3 <= 16'(lim(pwdata_i, `RM_SW_MIN, `RM_SW_MAX));
        `RM_OFF_SW4:   co_reg.sw4 <= 16'(lim(pwdata_i, `RM_SW_MIN, `RM_SW_MAX));
        `RM_OFF_HYST:  co_reg.hyst <= 8'(lim(pwdata_i, 32'h0, `RM_HYST_MAX));
        default:       ;
      endcase
    end
  end

  // Four identical parameter sets
  always_ff @(posedge clock_i)
  begin
    if (rst_i)
    begin
      for (int s = 0; s < 4; s++)
      begin
        pid_reg[s] <= `RM_PID_DEFAULT;
      end
    end
    else if (wr_en && pid_hit)
    begin
      case (paddr_i[3:2])
        2'h0: pid_reg[paddr_i[5:4]].proportional_gain <=
                16'(lim(pwdata_i, 32'h0, `RM_GAIN_MAX));
        2'h1: pid_reg[paddr_i[5:4]].integral_time <=
                18'(lim(pwdata_i, 32'h0, `RM_ITIME_MAX));
        2'h2: pid_reg[paddr_i[5:4]].derivative_time <=
                15'(lim(pwdata_i, `RM_DTIME_MIN, `RM_DTIME_MAX));
        default: pid_reg[paddr_i[5:4]].boost <=
                10'(lim(pwdata_i, 32'h0, `RM_BOOST_MAX));
      endcase
    end
  end

  // Variable source value, saturated at full scale
  always_comb
  begin
    unique case (ctrl_reg.source)
      src_an1:    var_val = analog_i[0];
      src_an2:    var_val = analog_i[1];
      src_an3:    var_val = analog_i[2];
      src_an4:    var_val = analog_i[3];
      src_motpot: var_val = motor_pot_i;
      default:    var_val = 16'h0000;
    endcase
    if (40'(var_val) > 40'(`RM_PCT_FULL))
    begin
      var_val = 16'(`RM_PCT_FULL);
    end
  end

  assign n_units = count_on({virt_in_i, dig_level});

  // Raw modification, in hundredths; 1 % maps to 1 Hz in control
  always_comb
  begin
    unique case (ctrl_reg.source)
      src_none:     delta_raw = 40'sh0;
      src_digvirt:  delta_raw = $signed(40'(n_units) * 40'(disc_reg));
      src_extender: delta_raw = ctrl_reg.regulation ? 40'sh0 :
                                $signed(40'(ext_units_i) * 40'(disc_reg));
      default:      delta_raw = $signed(40'(var_val) * 40'(17'(lower_reg) + 17'(upper_reg)))
                                / `RM_PCT_FULL - $signed(40'(lower_reg));
    endcase
    delta_scaled = ctrl_reg.grad_ref ?
                   delta_raw * $signed(40'(ref_i)) / `RM_PCT_FULL : delta_raw;
    delta_signed = ctrl_reg.inverse ? -delta_scaled : delta_scaled;
    sum = $signed(40'(ref_i)) + delta_signed;
  end

  // Clamp to frequency or reference limits
  always_comb
  begin
    lo_lim = ctrl_reg.regulation ? rmin_reg : fmin_reg;
    hi_lim = ctrl_reg.regulation ? rmax_reg : fmax_reg;
    if (sum < $signed(40'(lo_lim)))
    begin
      mod_ref_next = lo_lim;
    end
    else if (sum > $signed(40'(hi_lim)))
    begin
      mod_ref_next = hi_lim;
    end
    else
    begin
      mod_ref_next = sum[VW-1:0];
    end
  end

  // Output registers
  always_ff @(posedge clock_i)
  begin
    if (rst_i)
    begin
      mod_ref_o     <= '0;
      error_o       <= '0;
      active_set_o  <= `RM_PID_DEFAULT;
      set_idx_o     <= param_set_one;
      integral_on_o <= 1'b1;
    end
    else
    begin
      mod_ref_o     <= mod_ref_next;
      error_o       <= $signed({1'b0, mod_ref_next}) - $signed({1'b0, feedback_i});
      active_set_o  <= pid_reg[set_sel];
      set_idx_o     <= set_sel;
      integral_on_o <= pid_reg[set_sel].integral_time != 18'h00000;
    end
  end

  sequence apb_first_access;
    psel_i && penable_i && !pready_o;
  endsequence

  sequence apb_done;
    pready_o ##1 !pready_o;
  endsequence

  a_apb_wait: assert property (apb_first_access |=> apb_done)
    else $error("APB answer not one cycle after access");

  a_none_passes: assert property (ctrl_reg.source == src_none |-> delta_signed == 40'sh0)
    else $error("none source modified the reference");

  a_normal_raises: assert property (!ctrl_reg.inverse && delta_scaled > 40'sh0
    |-> sum > $signed(40'(ref_i)))
    else $error("normal sense did not raise");

  a_inverse_lowers: assert property (ctrl_reg.inverse && delta_scaled > 40'sh0
    |-> sum < $signed(40'(ref_i)))
    else $error("inverse sense did not lower");

  a_var_minimum: assert property (ctrl_reg.source == src_motpot && motor_pot_i == 16'h0000
    |-> delta_raw == -$signed(40'(lower_reg)))
    else $error("lower extent not applied at minimum");

  a_disc_step: assert property (ctrl_reg.source == src_digvirt && !ctrl_reg.inverse
    && !ctrl_reg.grad_ref |-> sum == $signed(40'(ref_i)) + $signed(40'(n_units) * 40'(disc_reg)))
    else $error("discrete step count wrong");

  a_ext_control: assert property (ctrl_reg.source == src_extender && ctrl_reg.regulation
    |-> delta_raw == 40'sh0)
    else $error("extender modified in regulation");

  a_clamp_ctrl: assert property (!ctrl_reg.regulation && fmin_reg <= fmax_reg
    |=> mod_ref_o >= $past(fmin_reg) && mod_ref_o <= $past(fmax_reg))
    else $error("control reference outside frequency limits");

  a_clamp_reg: assert property (ctrl_reg.regulation && rmin_reg <= rmax_reg
    |=> mod_ref_o >= $past(rmin_reg) && mod_ref_o <= $past(rmax_reg))
    else $error("regulation reference outside limits");

  a_integral_off: assert property (pid_reg[set_sel].integral_time == 18'h00000
    |=> !integral_on_o)
    else $error("integral term on with time off");

endmodule

// [rtl/rm_map.svh]
// Purpose: Register offsets, reset values and limits of the reference modifier
// Assumes: Percent and hertz values in hundredths, change-over values in tenths
// Notes:   Definitions only
`ifndef RM_MAP_SVH
`define RM_MAP_SVH

// Register byte offsets
`define RM_OFF_CTRL     8'h00
`define RM_OFF_LOWER    8'h04
`define RM_OFF_UPPER    8'h08
`define RM_OFF_DISC     8'h0C
`define RM_OFF_FMIN     8'h10
`define RM_OFF_FMAX     8'h14
`define RM_OFF_RMIN     8'h18
`define RM_OFF_RMAX     8'h1C
`define RM_OFF_SW2      8'h20
`define RM_OFF_SW3      8'h24
`define RM_OFF_SW4      8'h28
`define RM_OFF_HYST     8'h2C
`define RM_OFF_STATUS   8'h30
`define RM_PID_REGION   2'h1

// Status field positions
`define RM_ST_SET_LSB   20
`define RM_ST_INT_BIT   24

// Reset values, full scale and range limits
`define RM_PCT_FULL     40'sh0000002710
`define RM_PCT_MAX      32'h00007530
`define RM_LOWER_DEF    16'h01F4
`define RM_UPPER_DEF    16'h01F4
`define RM_DISC_DEF     16'h0000
`define RM_FMIN_DEF     18'h00000
`define RM_FMAX_DEF     18'h01388
`define RM_RMIN_DEF     18'h00000
`define RM_RMAX_DEF     18'h02710
`define RM_SW2_DEF      16'h00C8
`define RM_SW3_DEF      16'h012C
`define RM_SW4_DEF      16'h0190
`define RM_SW_MIN       32'h00000001
`define RM_SW_MAX       32'h00002710
`define RM_HYST_DEF     8'h0A
`define RM_HYST_MAX     32'h00000064
`define RM_GAIN_MAX     32'h00002EE0
`define RM_ITIME_MAX    32'h00030D40
`define RM_DTIME_MIN    32'h0000000A
`define RM_DTIME_MAX    32'h00004E20
`define RM_BOOST_MAX    32'h000003E7
`define RM_PID_DEFAULT  {16'h0032, 18'h00064, 15'h000A, 10'h000}

`endif

// [rtl/rm_pkg.sv]
// Purpose: Types shared by the reference modifier files
// Assumes: Nothing beyond SystemVerilog packed types
// Notes:   Offsets and values live in rm_map.svh
package rm_pkg;

  typedef enum logic [2:0] {
    src_none     = 3'h0,
    src_digvirt  = 3'h1,
    src_extender = 3'h2,
    src_an1      = 3'h3,
    src_an2      = 3'h4,
    src_an3      = 3'h5,
    src_an4      = 3'h6,
    src_motpot   = 3'h7
  } mod_src_t;

  typedef enum logic [2:0] {
    sel_one   = 3'h0,
    sel_two   = 3'h1,
    sel_three = 3'h2,
    sel_four  = 3'h3,
    sel_freq  = 3'h4
  } pid_sel_t;

  typedef enum logic [1:0] {
    param_set_one   = 2'h0,
    param_set_two   = 2'h1,
    param_set_three = 2'h2,
    param_set_four  = 2'h3
  } set_idx_t;

  typedef struct packed {
    pid_sel_t pid_sel;
    logic     regulation;
    logic     grad_ref;
    logic     inverse;
    mod_src_t source;
  } ctrl_t;

  typedef struct packed {
    logic [15:0] proportional_gain;
    logic [17:0] integral_time;
    logic [14:0] derivative_time;
    logic [9:0]  boost;
  } pid_set_t;

  typedef struct packed {
    logic [15:0] sw2;
    logic [15:0] sw3;
    logic [15:0] sw4;
    logic [7:0]  hyst;
  } changeover_t;

endpackage

// [rtl/rm_pin_sync.sv]
// Purpose: Three-flop synchroniser for pin inputs
// Assumes: Pins are asynchronous to clock_i
// Notes:   A change counts once the second and third stage agree
`timescale 1ns/100ps
module rm_pin_sync
  import rm_pkg::*;
#(
  parameter int W = 8
)(
  input  wire logic         clock_i,
  input  wire logic         rst_i,
  input  wire logic [W-1:0] pin_i,
  output logic      [W-1:0] level_o
);

  logic [W-1:0] stage1_reg;
  logic [W-1:0] stage2_reg;
  logic [W-1:0] stage3_reg;

  // Shift chain, first stage feeds only the second
  always_ff @(posedge clock_i)
  begin
    stage1_reg <= pin_i;
    stage2_reg <= stage1_reg;
    stage3_reg <= stage2_reg;
  end

  // Accept a bit only when the two late stages agree
  always_ff @(posedge clock_i)
  begin
    if (rst_i)
    begin
      level_o <= '0;
    end
    else
    begin
      for (int i = 0; i < W; i++)
      begin
        if (stage2_reg[i] == stage3_reg[i])
        begin
          level_o[i] <= stage2_reg[i];
        end
      end
    end
  end

endmodule

// [rtl/rm_pid_select.sv]
// Purpose: Chooses the active parameter set, fixed or by output frequency
// Assumes: Frequency and change-over points in tenths of a hertz
// Notes:   One step per clock, so a large jump settles in up to three cycles
`timescale 1ns/100ps
module rm_pid_select
  import rm_pkg::*;
(
  input  wire logic        clock_i,
  input  wire logic        rst_i,
  input  wire pid_sel_t    sel_i,
  input  wire logic [15:0] freq_i,
  input  wire changeover_t co_i,
  output set_idx_t         set_o
);

  logic [15:0] up_thr;
  logic [15:0] own_thr;
  logic [15:0] dn_thr;
  set_idx_t    freq_next;

  // Thresholds around the current set
  always_comb
  begin
    unique case (set_o)
      param_set_one:   begin up_thr = co_i.sw2; own_thr = 16'h0000;  end
      param_set_two:   begin up_thr = co_i.sw3; own_thr = co_i.sw2; end
      param_set_three: begin up_thr = co_i.sw4; own_thr = co_i.sw3; end
      param_set_four:  begin up_thr = 16'hFFFF; own_thr = co_i.sw4; end
    endcase
    dn_thr = (own_thr > {8'h00, co_i.hyst}) ? own_thr - {8'h00, co_i.hyst} : 16'h0000;
  end

  // Rise past a point steps up, fall below point minus hysteresis steps down
  always_comb
  begin
    freq_next = set_o;
    if (set_o != param_set_four && freq_i >= up_thr)
    begin
      freq_next = set_idx_t'(set_o + 2'h1);
    end
    else if (set_o != param_set_one && freq_i < dn_thr)
    begin
      freq_next = set_idx_t'(set_o - 2'h1);
    end
  end

  // Active set register
  always_ff @(posedge clock_i)
  begin
    if (rst_i)
    begin
      set_o <= param_set_one;
    end
    else
    begin
      case (sel_i)
        sel_one:   set_o <= param_set_one;
        sel_two:   set_o <= param_set_two;
        sel_three: set_o <= param_set_three;
        sel_four:  set_o <= param_set_four;
        sel_freq:  set_o <= freq_next;
        default:   set_o <= set_o;              // Illegal codes hold
      endcase
    end
  end

  a_fixed_set: assert property (@(posedge clock_i) disable iff (rst_i)
    sel_i == sel_three |=> set_o == param_set_three)
    else $error("fixed selection not applied");

  a_freq_rise: assert property (@(posedge clock_i) disable iff (rst_i)
    sel_i == sel_freq && set_o == param_set_one && freq_i >= co_i.sw2
      |=> set_o == param_set_two)
    else $error("set two not entered at change-over");

  a_hyst_hold: assert property (@(posedge clock_i) disable iff (rst_i)
    sel_i == sel_freq && set_o == param_set_two && freq_i < co_i.sw3
      && co_i.sw2 >= {8'h00, co_i.hyst} && freq_i >= co_i.sw2 - {8'h00, co_i.hyst}
      |=> set_o == param_set_two)
    else $error("set left inside hysteresis band");

endmodule

// [tb/reference_modifier_pid_select_tb.sv]
// Purpose: Self-checking bench for the reference modifier and set selector
// Assumes: One wait state APB slave, feedback held at 10.00 throughout
// Notes:   Waits after input changes cover the pin synchroniser latency
`timescale 1ns/100ps
`include "rm_map.svh"
module reference_modifier_pid_select_tb
  import rm_pkg::*;
;
  logic              clock_i, rst_i, psel_i, penable_i, pwrite_i;
  logic [7:0]        paddr_i, dig_in_i;
  logic [31:0]       pwdata_i, prdata_o, rd;
  logic              pready_o, pslverr_o, er;
  logic [17:0]       ref_i, feedback_i, mod_ref_o;
  logic [15:0]       out_freq_i, motor_pot_i;
  logic [5:0]        virt_in_i;
  logic [3:0]        ext_units_i;
  logic [3:0][15:0]  analog_i;
  logic signed [18:0] error_o;
  pid_set_t          active_set_o;
  set_idx_t          set_idx_o;
  logic              integral_on_o;
  int                n_errors, cmp_count;

  reference_modifier_pid_select i_dut (.clock_i(clock_i), .rst_i(rst_i), .psel_i(psel_i),
    .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i),
    .prdata_o(prdata_o), .pready_o(pready_o), .pslverr_o(pslverr_o), .ref_i(ref_i),
    .feedback_i(feedback_i), .out_freq_i(out_freq_i), .dig_in_i(dig_in_i),
    .virt_in_i(virt_in_i), .ext_units_i(ext_units_i), .analog_i(analog_i),
    .motor_pot_i(motor_pot_i), .mod_ref_o(mod_ref_o), .error_o(error_o),
    .active_set_o(active_set_o), .set_idx_o(set_idx_o), .integral_on_o(integral_on_o));

  // Clock at 250 MHz
  initial
  begin
    clock_i = 0;
    forever #2 clock_i = ~clock_i;
  end

  // Compare and count
  task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
    cmp_count++;
    if (seen !== exp)
    begin
      n_errors++;
      $display("mismatch at %0t: seen %0h expected %0h", $time, seen, exp);
    end
  endtask

  // Verdict and end of run
  task automatic end_sim();
    $display("errors %0d compares %0d", n_errors, cmp_count);
    if (n_errors == 0 && cmp_count > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  // One APB transfer, held until pready is sampled high
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clock_i);
    psel_i <= 1; penable_i <= 0; pwrite_i <= w; paddr_i <= a; pwdata_i <= d;
    @(posedge clock_i);
    penable_i <= 1;
    do
    begin
      @(posedge clock_i);
    end
    while (pready_o !== 1'b1);
    rd = prdata_o;
    er = pslverr_o;
    psel_i <= 0; penable_i <= 0;
  endtask

  function automatic logic [31:0] cw(mod_src_t s, logic inv, logic gr, logic rg, pid_sel_t p);
    ctrl_t c;
    c = '{p, rg, gr, inv, s};
    return {23'h0, c};
  endfunction

  // Apply a reference and judge output and error
  task automatic dp(input int r, input int exp);
    ref_i <= 18'(r);
    repeat (8) @(posedge clock_i);
    chk(64'(mod_ref_o), 64'(exp));
    chk({45'h0, error_o}, {45'h0, 19'(exp - 1000)});
  endtask

  // Reset values, saturation and unmapped access
  task automatic t_regs();
    apb(0, `RM_OFF_CTRL, 0);   chk(64'(rd), 0);
    apb(0, `RM_OFF_LOWER, 0);  chk(64'(rd), `RM_LOWER_DEF);
    apb(0, `RM_OFF_UPPER, 0);  chk(64'(rd), `RM_UPPER_DEF);
    apb(0, `RM_OFF_DISC, 0);   chk(64'(rd), `RM_DISC_DEF);
    apb(0, `RM_OFF_SW2, 0);    chk(64'(rd), `RM_SW2_DEF);
    apb(0, `RM_OFF_HYST, 0);   chk(64'(rd), `RM_HYST_DEF);
    apb(0, 8'h70, 0);          chk(64'(rd), 64'h32);
    apb(1, `RM_OFF_LOWER, 32'h00009C40);
    apb(0, `RM_OFF_LOWER, 0);  chk(64'(rd), `RM_PCT_MAX);
    apb(1, `RM_OFF_LOWER, `RM_LOWER_DEF);
    apb(0, 8'h34, 0);          chk(64'({er, rd}), 64'h100000000);
  endtask

  // Source none, discrete, variable and clamping
  task automatic t_mod();
    dp(3000, 3000);
    apb(1, `RM_OFF_DISC, 32'h64);
    virt_in_i <= 6'h03; dig_in_i <= 8'h01;
    apb(1, `RM_OFF_CTRL, cw(src_digvirt, 0, 0, 0, sel_one));
    dp(3000, 3300);
    apb(1, `RM_OFF_CTRL, cw(src_digvirt, 1, 0, 0, sel_one));
    dp(3000, 2700);
    analog_i <= {16'h1388, 16'h4E20, 16'h0000, 16'h2710}; motor_pot_i <= 16'h0000;
    apb(1, `RM_OFF_UPPER, 32'h320);
    apb(1, `RM_OFF_CTRL, cw(src_an1, 0, 0, 0, sel_one));
    dp(3000, 3800);
    dp(4900, 5000);
    apb(1, `RM_OFF_CTRL, cw(src_an1, 1, 0, 0, sel_one));
    dp(3000, 2200);
    apb(1, `RM_OFF_CTRL, cw(src_an2, 0, 0, 0, sel_one));
    dp(3000, 2500);
    apb(1, `RM_OFF_CTRL, cw(src_an3, 0, 0, 0, sel_one));
    dp(3000, 3800);
    apb(1, `RM_OFF_CTRL, cw(src_an4, 0, 0, 0, sel_one));
    dp(3000, 3150);
    apb(1, `RM_OFF_CTRL, cw(src_motpot, 0, 0, 0, sel_one));
    dp(3000, 2500);
    dp(200, 0);
    apb(1, `RM_OFF_CTRL, cw(src_motpot, 1, 0, 0, sel_one));
    dp(3000, 3500);
    apb(1, `RM_OFF_CTRL, cw(src_an1, 0, 1, 1, sel_one));
    dp(5000, 5400);
    apb(1, `RM_OFF_CTRL, cw(src_an1, 0, 0, 1, sel_one));
    dp(9800, 10000);
    ext_units_i <= 4'h3;
    apb(1, `RM_OFF_CTRL, cw(src_extender, 0, 0, 0, sel_one));
    dp(1000, 1300);
    apb(1, `RM_OFF_CTRL, cw(src_extender, 0, 0, 1, sel_one));
    dp(1000, 1000);
  endtask

  // Fixed and frequency-dependent set choice
  task automatic t_sets();
    apb(1, `RM_OFF_CTRL, cw(src_none, 0, 0, 1, sel_three));
    repeat (4) @(posedge clock_i);
    chk(64'(set_idx_o), 64'(param_set_three));
    apb(1, `RM_OFF_CTRL, cw(src_none, 0, 0, 1, sel_two));
    repeat (4) @(posedge clock_i);
    chk(64'(set_idx_o), 64'(param_set_two));
    apb(1, `RM_OFF_CTRL, cw(src_none, 0, 0, 1, sel_freq));
    out_freq_i <= 16'd250; repeat (8) @(posedge clock_i);
    chk(64'(set_idx_o), 64'(param_set_two));
    out_freq_i <= 16'd195; repeat (8) @(posedge clock_i);
    chk(64'(set_idx_o), 64'(param_set_two));
    out_freq_i <= 16'd189; repeat (8) @(posedge clock_i);
    chk(64'(set_idx_o), 64'(param_set_one));
    out_freq_i <= 16'd450; repeat (8) @(posedge clock_i);
    chk(64'(set_idx_o), 64'(param_set_four));
    apb(1, `RM_OFF_CTRL, cw(src_none, 0, 0, 1, sel_one));
    apb(1, 8'h44, 0);
    repeat (4) @(posedge clock_i);
    chk(64'(integral_on_o), 0);
    chk(64'(active_set_o.proportional_gain), 64'h32);
    apb(0, `RM_OFF_STATUS, 0); chk(64'(rd), 64'h3E8);
  endtask

  // Watchdog
  initial
  begin
    #200000;
    n_errors++;
    end_sim();
  end

  // Main sequence
  initial
  begin
    rst_i = 1; psel_i = 0; penable_i = 0; pwrite_i = 0; paddr_i = 0; pwdata_i = 0;
    ref_i = 0; feedback_i = 18'd1000; out_freq_i = 0; dig_in_i = 0; virt_in_i = 0;
    ext_units_i = 0; analog_i = '0; motor_pot_i = 0; n_errors = 0; cmp_count = 0;
    repeat (3) @(posedge clock_i);
    rst_i <= 0;
    t_regs();
    t_mod();
    t_sets();
    end_sim();
  end
endmodule
